// File: pkg/cma_pkg.sv
// Constants, field layouts and carrier types of the core memory addressing block.
// Assumes one clock domain; shared by the design and the bench.
package cma_pkg;
  // ==========================================================================
  // Program space
  localparam int          PC_W         = 15;
  localparam int          PROG_WORDS   = 16384;
  localparam int          HE_WORDS     = 128;
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR   = 15'h0004;
  localparam int          STK_DEPTH    = 16;
  // ==========================================================================
  // Data space
  localparam int          DADDR_W      = 12;
  localparam int          BANKS        = 32;
  localparam int          BANK_BYTES   = 128;
  localparam int          GPR_BYTES    = 80;
  localparam logic [6:0]  CORE_REGS    = 7'h0C;
  localparam logic [6:0]  GPR_BASE     = 7'h20;
  localparam logic [3:0]  LIN_REGION   = 4'h2;
  localparam logic [11:0] LIN_SIZE     = 12'h0A00;
  localparam logic [11:0] LIN_DIV      = 12'h0050;
  localparam int          PTR_PROG_BIT = 15;
  // ==========================================================================
  // Core register offsets
  localparam logic [6:0]  OFS_IND0     = 7'h00;
  localparam logic [6:0]  OFS_IND1     = 7'h01;
  localparam logic [6:0]  OFS_PCL      = 7'h02;
  localparam logic [6:0]  OFS_STATUS   = 7'h03;
  localparam logic [6:0]  OFS_P0L      = 7'h04;
  localparam logic [6:0]  OFS_P0H      = 7'h05;
  localparam logic [6:0]  OFS_P1L      = 7'h06;
  localparam logic [6:0]  OFS_P1H      = 7'h07;
  localparam logic [6:0]  OFS_BSR      = 7'h08;
  localparam logic [6:0]  OFS_WORKING_REGISTER     = 7'h09;
  localparam logic [6:0]  OFS_PROGRAM_COUNTER_LATCH_HIGH   = 7'h0A;
  localparam logic [6:0]  OFS_INTERRUPT_CONTROL   = 7'h0B;
  // ==========================================================================
  // Status fields and reset values
  localparam int          ST_TO        = 4;
  localparam int          ST_PD        = 3;
  localparam int          ST_Z         = 2;
  localparam int          ST_DC        = 1;
  localparam int          ST_C         = 0;
  localparam logic [7:0]  STATUS_RST   = 8'h18;
  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [15:0] PTR_RST      = 16'h0000;
  // ==========================================================================
  // Carrier types
  typedef enum logic [2:0] {PC_HOLD, PC_STEP, PC_LOAD, PC_CALL, PC_RET, PC_IRQ, PC_RETFIE}
    cma_pcop_t;
  typedef enum logic [1:0] {TK_CORE, TK_RAM, TK_PROG, TK_NONE} cma_kind_t;
  typedef struct packed {cma_pcop_t op; logic [14:0] target;} cma_pccmd_t;
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [6:0] ofs;
    logic [7:0] wdata;
    logic [2:0] fmask;   // Z, DC, C touched by the instruction
    logic [2:0] fval;
  } cma_acc_t;
  typedef struct packed {logic valid; logic sub; logic [7:0] a; logic [7:0] b;} cma_alu_t;
  typedef struct packed {logic clrwdt; logic sleep; logic wdt_to;} cma_pwr_t;
  typedef struct packed {logic valid; logic [7:0] rdata;} cma_rsp_t;
  typedef struct packed {logic valid; logic wr; logic [11:0] addr; logic [7:0] wdata;} cma_ram_t;
  typedef struct packed {cma_kind_t kind; logic [14:0] addr;} cma_tgt_t;
endpackage : cma_pkg

// File: design/cma_core.sv
// Core memory addressing: program counter, return stack, banked data access,
// indirect pointers, core register file and status flag handling.
// Assumes the CPU issues at most one access and one pc command per cycle and
// that data RAM and flash answer in the same cycle their request is shown.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Shadow core registers on interrupt, restore on return
// - Return stack is 16 entries of 15 bits
// - Stack over/underflow flags, optional software reset
// - Two 16-bit pointers reach data and program
// - Program access via port takes extra cycle
// - Pointers give linear view of general RAM
// - Program counter is 15 bits wide
// - Program addresses wrap inside implemented size
// - Reset starts at 0000h, interrupt at 0004h
// - Top 128 program words are high-endurance
// - Pointer bit 15 reads program low byte
// - Port writes never modify program memory
// - Thirty-two banks of 128 bytes each
// - Direct accesses use the bank select register
// - Unimplemented data locations read as zero
// - Twelve-bit data address: bank plus offset
// - First twelve offsets are the core registers
// - Flag-affecting writes to status keep result flags
// - Timeout and sleep flags ignore software writes
// - Clearing status gives 000u u1uu
// - Carry flags act as inverted borrows
// - Status bit layout, upper three read zero
// - Nibble carry, carry and zero from result
// - Subtract by adding two's complement
module cma_core
  import cma_pkg::*;
#(
  parameter int PROG_SIZE = PROG_WORDS
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire cma_acc_t   acc,
  input  wire cma_alu_t   alu,
  input  wire cma_pccmd_t pc_cmd,
  input  wire cma_pwr_t   pwr,
  input  wire logic       stack_reset_en,
  input  wire logic [1:0] stack_flag_clr,
  input  wire logic [7:0] ram_rdata,
  input  wire logic       ram_hit,
  input  wire logic [13:0] flash_rdata,
  output logic            acc_ready_q,
  output cma_rsp_t        acc_rsp_q,
  output cma_ram_t        ram_req_q,
  output logic            flash_rd_q,
  output logic [14:0]     flash_addr_q,
  output logic            flash_he_q,
  output logic [14:0]     pc_q,
  output logic [7:0]      status_q,
  output logic [7:0]      working_register_q,
  output logic [7:0]      alu_res_q,
  output logic            stack_over_flag_q,
  output logic            stack_under_flag_q,
  output logic            soft_reset_q
);
  // ==========================================================================
  // Registers
  localparam logic [14:0] PC_MASK = 15'(PROG_SIZE - 1);
  localparam logic [14:0] HE_BASE = 15'(PROG_SIZE - HE_WORDS);
  localparam logic [4:0]  SP_FULL = 5'(STK_DEPTH);

  typedef enum logic [1:0] {AS_IDLE, AS_RAM, AS_PROG, AS_XTRA} cma_acst_t;

  logic [15:0] ptr0_q, ptr1_q;
  logic [4:0]  bank_select_q;
  logic [6:0]  program_counter_latch_high_q;
  logic [7:0]  interrupt_control_q;
  logic [2:0]  sh_flags_q;
  logic [7:0]  sh_working_register_q;
  logic [4:0]  sh_bsr_q;
  logic [6:0]  sh_program_counter_latch_high_q;
  logic [15:0] sh_ptr0_q, sh_ptr1_q;
  logic [14:0] stack_q [STK_DEPTH];
  logic [4:0]  sp_q;
  logic [7:0]  prog_byte_q;
  cma_acst_t   as_q, as_d;

  // ==========================================================================
  // Target decode
  function automatic cma_tgt_t resolve(input logic [15:0] p);
    cma_tgt_t   t;
    logic [11:0] lin;
    t.kind = TK_NONE;
    t.addr = '0;
    lin    = p[11:0];
    if (p[PTR_PROG_BIT]) begin
      t.kind = TK_PROG;
      t.addr = p[14:0] & PC_MASK;
    end else if (p[15:12] == 4'h0) begin
      if (p[6:0] < CORE_REGS) begin
        t.kind = (p[6:0] > OFS_IND1) ? TK_CORE : TK_NONE;
        t.addr = {8'h00, p[6:0]};
      end else begin
        t.kind = TK_RAM;
        t.addr = {3'b000, p[11:0]};
      end
    end else if (p[15:12] == LIN_REGION && lin < LIN_SIZE) begin
      t.kind = TK_RAM;
      t.addr = {3'b000, 5'(lin / LIN_DIV), 7'(lin % LIN_DIV) + GPR_BASE};
    end
    return t;
  endfunction : resolve

  cma_tgt_t tgt;
  always_comb begin
    tgt.kind = TK_CORE;
    tgt.addr = {8'h00, acc.ofs};
    if (acc.ofs == OFS_IND0) begin
      tgt = resolve(ptr0_q);
    end else if (acc.ofs == OFS_IND1) begin
      tgt = resolve(ptr1_q);
    end else if (acc.ofs >= CORE_REGS) begin
      tgt.kind = TK_RAM;
      tgt.addr = {3'b000, bank_select_q, acc.ofs};
    end
  end

  wire logic take = acc.valid & acc_ready_q;
  wire logic cw_en = take & acc.wr & (tgt.kind == TK_CORE);
  wire logic [6:0] cw_ofs = tgt.addr[6:0];

  function automatic logic [7:0] core_rd(input logic [6:0] o);
    logic [7:0] v;
    case (o)
      OFS_PCL:    v = pc_q[7:0];
      OFS_STATUS: v = status_q;
      OFS_P0L:    v = ptr0_q[7:0];
      OFS_P0H:    v = ptr0_q[15:8];
      OFS_P1L:    v = ptr1_q[7:0];
      OFS_P1H:    v = ptr1_q[15:8];
      OFS_BSR:    v = {3'b000, bank_select_q};
      OFS_WORKING_REGISTER:   v = working_register_q;
      OFS_PROGRAM_COUNTER_LATCH_HIGH: v = {1'b0, program_counter_latch_high_q};
      OFS_INTERRUPT_CONTROL: v = interrupt_control_q;
      default:    v = 8'h00;
    endcase
    return v;
  endfunction : core_rd

  // ==========================================================================
  // Access sequencer
  always_comb begin
    as_d = as_q;
    case (as_q)
      AS_IDLE: begin
        if (take && !acc.wr && tgt.kind == TK_RAM) as_d = AS_RAM;
        if (take && !acc.wr && tgt.kind == TK_PROG) as_d = AS_PROG;
      end
      AS_RAM:  as_d = AS_IDLE;
      AS_PROG: as_d = AS_XTRA;
      AS_XTRA: as_d = AS_IDLE;
      default: as_d = AS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      as_q         <= AS_IDLE;
      acc_ready_q  <= 1'b0;
      acc_rsp_q    <= '0;
      ram_req_q    <= '0;
      flash_rd_q   <= 1'b0;
      flash_addr_q <= '0;
      flash_he_q   <= 1'b0;
      prog_byte_q  <= 8'h00;
    end else begin
      as_q        <= as_d;
      acc_ready_q <= (as_d == AS_IDLE);
      acc_rsp_q   <= '0;
      ram_req_q   <= '0;
      flash_rd_q  <= 1'b0;
      if (take) begin
        if (tgt.kind == TK_RAM) begin
          ram_req_q <= '{valid: 1'b1, wr: acc.wr, addr: tgt.addr[11:0], wdata: acc.wdata};
        end
        if (tgt.kind == TK_PROG && !acc.wr) begin
          flash_rd_q   <= 1'b1;
          flash_addr_q <= tgt.addr;
          flash_he_q   <= (tgt.addr >= HE_BASE);
        end
        if (acc.wr || tgt.kind == TK_CORE || tgt.kind == TK_NONE) begin
          acc_rsp_q.valid <= 1'b1;
          acc_rsp_q.rdata <= (acc.wr || tgt.kind == TK_NONE) ? 8'h00 : core_rd(cw_ofs);
        end
      end
      if (as_q == AS_RAM) begin
        acc_rsp_q <= '{valid: 1'b1, rdata: ram_hit ? ram_rdata : 8'h00};
      end
      if (as_q == AS_PROG) prog_byte_q <= flash_rdata[7:0];
      if (as_q == AS_XTRA) acc_rsp_q <= '{valid: 1'b1, rdata: prog_byte_q};
    end
  end

  // ==========================================================================
  // Pointers, bank, working register, latch and shadows
  wire logic irq_in = (pc_cmd.op == PC_IRQ);
  wire logic irq_out = (pc_cmd.op == PC_RETFIE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ptr0_q                       <= PTR_RST;
      ptr1_q                       <= PTR_RST;
      bank_select_q                <= '0;
      working_register_q           <= REG_RST;
      program_counter_latch_high_q <= '0;
      interrupt_control_q          <= REG_RST;
      sh_working_register_q                    <= REG_RST;
      sh_bsr_q                     <= '0;
      sh_program_counter_latch_high_q                  <= '0;
      sh_ptr0_q                    <= PTR_RST;
      sh_ptr1_q                    <= PTR_RST;
    end else if (irq_out) begin
      working_register_q           <= sh_working_register_q;
      bank_select_q                <= sh_bsr_q;
      program_counter_latch_high_q <= sh_program_counter_latch_high_q;
      ptr0_q                       <= sh_ptr0_q;
      ptr1_q                       <= sh_ptr1_q;
    end else begin
      if (irq_in) begin
        sh_working_register_q   <= working_register_q;
        sh_bsr_q    <= bank_select_q;
        sh_program_counter_latch_high_q <= program_counter_latch_high_q;
        sh_ptr0_q   <= ptr0_q;
        sh_ptr1_q   <= ptr1_q;
      end
      if (cw_en) begin
        case (cw_ofs)
          OFS_P0L:    ptr0_q[7:0]  <= acc.wdata;
          OFS_P0H:    ptr0_q[15:8] <= acc.wdata;
          OFS_P1L:    ptr1_q[7:0]  <= acc.wdata;
          OFS_P1H:    ptr1_q[15:8] <= acc.wdata;
          OFS_BSR:    bank_select_q <= acc.wdata[4:0];
          OFS_WORKING_REGISTER:   working_register_q <= acc.wdata;
          OFS_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high_q <= acc.wdata[6:0];
          OFS_INTERRUPT_CONTROL: interrupt_control_q <= acc.wdata;
          default:    ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Status and flag arithmetic
  logic [7:0] alu_b;
  logic [8:0] alu_sum;
  logic [4:0] alu_nib;
  always_comb begin
    alu_b   = alu.sub ? ~alu.b : alu.b;
    alu_sum = {1'b0, alu.a} + {1'b0, alu_b} + {8'h00, alu.sub};
    alu_nib = {1'b0, alu.a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu.sub};
  end

  wire logic st_wr = cw_en & (cw_ofs == OFS_STATUS);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_q   <= STATUS_RST;
      alu_res_q  <= REG_RST;
      sh_flags_q <= '0;
    end else begin
      if (alu.valid) begin
        alu_res_q          <= alu_sum[7:0];
        status_q[ST_C]     <= alu_sum[8];
        status_q[ST_DC]    <= alu_nib[4];
        status_q[ST_Z]     <= (alu_sum[7:0] == 8'h00);
      end
      if (st_wr && acc.fmask == 3'b000) begin
        status_q[2:0] <= acc.wdata[2:0];
      end
      if (cw_en && acc.fmask != 3'b000) begin
        // Status as destination: the data is dropped for all three flags
        if (acc.fmask[2]) status_q[ST_Z]  <= acc.fval[2];
        if (acc.fmask[1]) status_q[ST_DC] <= acc.fval[1];
        if (acc.fmask[0]) status_q[ST_C]  <= acc.fval[0];
      end
      if (pwr.clrwdt) status_q[ST_TO:ST_PD] <= 2'b11;
      if (pwr.sleep) status_q[ST_PD] <= 1'b0;
      if (pwr.wdt_to) status_q[ST_TO] <= 1'b0;
      status_q[7:5] <= 3'b000;
      if (irq_in) sh_flags_q <= status_q[2:0];
      if (irq_out) status_q[2:0] <= sh_flags_q;
    end
  end

  // ==========================================================================
  // Program counter and return stack
  wire logic push = (pc_cmd.op == PC_CALL) || irq_in;
  wire logic pop  = (pc_cmd.op == PC_RET) || irq_out;
  wire logic [14:0] pc_inc = (pc_q + 15'h0001) & PC_MASK;
  wire logic [14:0] pop_val = (sp_q == 5'd0) ? RESET_VECTOR : stack_q[4'(sp_q - 5'd1)];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_q <= RESET_VECTOR;
    end else begin
      case (pc_cmd.op)
        PC_STEP:           pc_q <= pc_inc;
        PC_LOAD, PC_CALL:  pc_q <= pc_cmd.target & PC_MASK;
        PC_RET, PC_RETFIE: pc_q <= pop_val & PC_MASK;
        PC_IRQ:            pc_q <= IRQ_VECTOR;
        default:           ;
      endcase
      if (cw_en && cw_ofs == OFS_PCL && pc_cmd.op == PC_HOLD) begin
        pc_q <= {program_counter_latch_high_q, acc.wdata} & PC_MASK;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push && sp_q != SP_FULL) begin
      stack_q[4'(sp_q)] <= irq_in ? pc_q : pc_inc;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sp_q               <= '0;
      stack_over_flag_q  <= 1'b0;
      stack_under_flag_q <= 1'b0;
      soft_reset_q       <= 1'b0;
    end else begin
      soft_reset_q <= 1'b0;
      if (stack_flag_clr[0]) stack_over_flag_q <= 1'b0;
      if (stack_flag_clr[1]) stack_under_flag_q <= 1'b0;
      if (push) begin
        if (sp_q == SP_FULL) begin
          stack_over_flag_q <= 1'b1;
          soft_reset_q      <= stack_reset_en;
        end else begin
          sp_q <= sp_q + 5'd1;
        end
      end
      if (pop) begin
        if (sp_q == 5'd0) begin
          stack_under_flag_q <= 1'b1;
          soft_reset_q       <= stack_reset_en;
        end else begin
          sp_q <= sp_q - 5'd1;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  irq_vector_a: assert property (irq_in |=> pc_q == IRQ_VECTOR)
    else $error("interrupt did not vector to 0004h");
  pc_wrap_a: assert property (pc_q <= PC_MASK)
    else $error("program counter beyond implemented space");
  stk_over_a: assert property (push && sp_q == SP_FULL |=> stack_over_flag_q && sp_q == SP_FULL)
    else $error("overflow not flagged");
  stk_under_a: assert property (pop && sp_q == 5'd0 && !push |=> stack_under_flag_q)
    else $error("underflow not flagged");
  stk_depth_a: assert property (sp_q <= SP_FULL)
    else $error("stack pointer past depth");
  prog_extra_a: assert property (take && !acc.wr && tgt.kind == TK_PROG
      |=> flash_rd_q && !acc_rsp_q.valid ##1 !acc_rsp_q.valid ##1 acc_rsp_q.valid)
    else $error("program read answer timing wrong");
  prog_nowrite_a: assert property (take && acc.wr && tgt.kind == TK_PROG
      |=> !flash_rd_q && !ram_req_q.valid)
    else $error("write reached memory through program pointer");
  direct_bank_a: assert property (take && acc.ofs >= CORE_REGS
      |=> ram_req_q.valid && ram_req_q.addr[11:7] == $past(bank_select_q))
    else $error("direct access ignored bank select");
  unimpl_zero_a: assert property (as_q == AS_RAM && !ram_hit |=> acc_rsp_q.rdata == 8'h00)
    else $error("unimplemented location read nonzero");
  status_top_a: assert property (status_q[7:5] == 3'b000)
    else $error("status upper bits not zero");
  tpd_keep_a: assert property (st_wr && pwr == '0 |=> $stable(status_q[ST_TO:ST_PD]))
    else $error("software wrote timeout or sleep flag");
  shadow_back_a: assert property (irq_in ##1 (pc_cmd.op == PC_HOLD && !cw_en)[*2]
      ##1 irq_out |=> working_register_q == $past(working_register_q, 4))
    else $error("working register not restored");
  sub_borrow_a: assert property (alu.valid && alu.sub && alu.a < alu.b && !cw_en && !irq_out
      |=> !status_q[ST_C])
    else $error("borrow polarity wrong");

  irq_round_c: cover property (irq_in ##[1:20] irq_out);
  prog_read_c: cover property (take && tgt.kind == TK_PROG && !acc.wr);
  linear_c: cover property (take && acc.ofs == OFS_IND0 && ptr0_q[15:12] == LIN_REGION);
  overflow_c: cover property (stack_over_flag_q);
endmodule : cma_core

`default_nettype wire

// File: verification/cma_mem_model.sv
// Data RAM and program flash seen from the core memory addressing block.
// Assumes requests are one-cycle pulses answered in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cma_mem_model
  import cma_pkg::*;
(
  input  wire logic        mclk,
  input  wire cma_ram_t    ram_req,
  input  wire logic        flash_rd,
  input  wire logic [14:0] flash_addr,
  output logic [7:0]       ram_rdata,
  output logic             ram_hit,
  output logic [13:0]      flash_rdata
);
  // ==========================================================================
  // Storage and idle patterns
  logic [7:0]  mem [4096];
  logic [7:0]  last_q   = 8'h5A;
  logic [13:0] last_w_q = 14'h2A5A;
  logic [11:0] eff;
  // Common bytes alias every bank onto bank 0
  assign eff = (ram_req.addr[6:4] == 3'h7) ? {5'h00, ram_req.addr[6:0]} : ram_req.addr;
  // Peripheral slots are absent here, so the core must zero them
  assign ram_hit = ram_req.valid && (ram_req.addr[6:0] >= 7'h20);
  // Idle lines toggle so a stale sample never looks valid
  assign ram_rdata   = (ram_req.valid && !ram_req.wr) ? mem[eff] : ~last_q;
  assign flash_rdata = flash_rd ? {flash_addr[13:8], flash_addr[7:0] ^ 8'h53} : ~last_w_q;
  // ==========================================================================
  // Write port
  always_ff @(posedge mclk) begin
    last_q   <= ram_rdata;
    last_w_q <= flash_rdata;
    if (ram_req.valid && ram_req.wr) begin
      mem[eff] <= ram_req.wdata;
    end
  end
endmodule : cma_mem_model
`default_nettype wire

// File: verification/core_memory_addressing_tb.sv
// Self-checking bench of the core memory addressing block.
// Assumes cma_mem_model stands for RAM and flash; small program variant.
`timescale 1ns/1ps
`default_nettype none
module core_memory_addressing_tb
  import cma_pkg::*;
;
  localparam int PS = 8192;
  logic        mclk = 0;
  logic        resetn = 0;
  cma_acc_t    acc = '0;
  cma_alu_t    alu = '0;
  cma_pccmd_t  pcc = '{PC_HOLD, 15'h0000};
  cma_pwr_t    pwr = '0;
  logic        sre = 1'b1;
  logic [1:0]  sfc = 2'b00;
  logic [7:0]  ram_rdata, working_register, ares, st, rd, a, b;
  logic        ram_hit, fl_rd, fl_he, rdy, ovf, unf, srst, he_seen, sb;
  logic [13:0] fl_rdata;
  logic [14:0] fl_addr, pc, pa;
  logic [15:0] p;
  logic [8:0]  s;
  logic [4:0]  h;
  cma_rsp_t    rsp;
  cma_ram_t    rq;
  int          errors = 0, checked = 0, seed = 90, srcnt = 0, wrcnt = 0;
  int          n, nr, pcm, k, w0, stk[$];
  cma_core #(.PROG_SIZE(PS)) i_dut (.mclk(mclk), .resetn(resetn), .acc(acc), .alu(alu),
    .pc_cmd(pcc), .pwr(pwr), .stack_reset_en(sre), .stack_flag_clr(sfc),
    .ram_rdata(ram_rdata), .ram_hit(ram_hit), .flash_rdata(fl_rdata), .acc_ready_q(rdy),
    .acc_rsp_q(rsp), .ram_req_q(rq), .flash_rd_q(fl_rd), .flash_addr_q(fl_addr),
    .flash_he_q(fl_he), .pc_q(pc), .status_q(st), .working_register_q(working_register),
    .alu_res_q(ares), .stack_over_flag_q(ovf), .stack_under_flag_q(unf),
    .soft_reset_q(srst));
  cma_mem_model i_mem (.mclk(mclk), .ram_req(rq), .flash_rd(fl_rd), .flash_addr(fl_addr),
    .ram_rdata(ram_rdata), .ram_hit(ram_hit), .flash_rdata(fl_rdata));
  initial begin
    forever #20 mclk = ~mclk;
  end
  // ==========================================================================
  // Event monitors
  always @(posedge mclk) begin
    if (srst === 1'b1) srcnt++;
    if (rq.valid === 1'b1 && rq.wr === 1'b1) wrcnt++;
    if (fl_rd === 1'b1) he_seen = fl_he;
  end
  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Request held until ready seen high; latency counts falling edges after the take edge
  task automatic acc_do(input logic w, input logic [6:0] o, input logic [7:0] d,
                        input logic [2:0] fm, input logic [2:0] fv);
    @(posedge mclk);
    acc <= '{1'b1, w, o, d, fm, fv};
    n = 0;
    @(negedge mclk);
    while (rdy !== 1'b1 && n < 9) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    acc.valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (rsp.valid !== 1'b1 && n < 9);
    if (rsp.valid !== 1'b1) begin
      errors++;
      summarize();
    end
    rd = rsp.rdata;
  endtask : acc_do
  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    acc_do(1'b1, o, d, 3'b000, 3'b000);
  endtask : wr
  task automatic rdv(input logic [6:0] o);
    acc_do(1'b0, o, 8'h00, 3'b000, 3'b000);
  endtask : rdv
  task automatic pw(input cma_pwr_t v, input logic [7:0] e);
    @(posedge mclk);
    pwr <= v;
    @(posedge mclk);
    pwr <= '0;
    @(negedge mclk);
    chk("status pwr", e, st);
  endtask : pw
  task automatic pc_do(input cma_pcop_t op, input logic [14:0] t);
    @(posedge mclk);
    pcc <= '{op, t};
    @(posedge mclk);
    pcc <= '{PC_HOLD, 15'h0000};
    @(negedge mclk);
    case (op)
      PC_STEP: pcm = (pcm + 1) % PS;
      PC_LOAD: pcm = t % PS;
      PC_CALL, PC_IRQ: begin
        if (stk.size() < 16) stk.push_back(op == PC_IRQ ? pcm : (pcm + 1) % PS);
        pcm = (op == PC_IRQ) ? 4 : t % PS;
      end
      default: pcm = (stk.size() > 0) ? stk.pop_back() : 0;
    endcase
    chk("pc", 16'(pcm), pc);
  endtask : pc_do
  task automatic flag_clr(input logic [1:0] v);
    @(posedge mclk);
    sfc <= v;
    @(posedge mclk);
    sfc <= 2'b00;
    @(negedge mclk);
  endtask : flag_clr
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    chk("pc reset", 0, pc);
    chk("status reset", 8'h18, st);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int o = 4; o < 12; o++) wr(7'(o), 8'(8'h10 + o));
    for (int o = 4; o < 12; o++) begin
      rdv(7'(o));
      chk("core reg", 8'(8'h10 + o), rd);
    end
    chk("working_register port", 8'h19, working_register);
    for (int i = 0; i < 6; i++) begin
      k = {$random(seed)} % 2560;
      a = 8'($random(seed));
      wr(OFS_BSR, 8'(k / 80));
      wr(7'(32 + k % 80), a);
      wr(OFS_BSR, 8'(31 - k / 80));
      p = 16'(32'h2000 + k);
      wr(OFS_P0H, p[15:8]);
      wr(OFS_P0L, p[7:0]);
      rdv(OFS_IND0);
      chk("linear", a, rd);
      nr = n;
      p = {4'h0, 5'(k / 80), 7'(32 + k % 80)};
      wr(OFS_P1H, p[15:8]);
      wr(OFS_P1L, p[7:0]);
      rdv(OFS_IND1);
      chk("pointer", a, rd);
    end
    wr(OFS_BSR, 8'h02);
    wr(7'h75, 8'h6E);
    wr(OFS_BSR, 8'h07);
    rdv(7'h75);
    chk("common", 8'h6E, rd);
    rdv(7'h0C);
    chk("unimpl", 8'h00, rd);
    for (int i = 0; i < 2; i++) begin
      pa = i ? 15'h1F90 : 15'h0123;
      wr(OFS_P1H, {1'b1, pa[14:8]});
      wr(OFS_P1L, pa[7:0]);
      rdv(OFS_IND1);
      chk("prog", pa[7:0] ^ 8'h53, rd);
      chk("extra cycle", 16'(nr + 1), 16'(n));
      chk("he", 16'(i), 16'(he_seen));
    end
    w0 = wrcnt;
    wr(OFS_IND1, 8'hAA);
    chk("no prog write", 16'(w0), 16'(wrcnt));
    for (int i = 0; i < 24; i++) begin
      a = 8'($random(seed));
      b = (i < 2) ? 8'h00 : 8'($random(seed));
      sb = i[0];
      @(posedge mclk);
      alu <= '{1'b1, sb, a, b};
      @(posedge mclk);
      alu.valid <= 1'b0;
      @(negedge mclk);
      s = sb ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
      h = sb ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01 : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      chk("alu", s[7:0], ares);
      chk("flags", {s[7:0] == 8'h00, h[4], s[8]}, st[2:0]);
    end
    pw(3'b010, {3'b000, 2'b10, st[2:0]});
    pw(3'b001, {3'b000, 2'b00, st[2:0]});
    wr(OFS_STATUS, 8'hFF);
    chk("status write", 8'h07, st);
    wr(OFS_STATUS, 8'h00);
    acc_do(1'b1, OFS_STATUS, 8'h00, 3'b100, 3'b100);
    chk("status clear", 8'h04, st);
    wr(OFS_STATUS, 8'h03);
    acc_do(1'b1, OFS_STATUS, 8'hFF, 3'b011, 3'b000);
    chk("status masked", 8'h00, st);
    pw(3'b100, 8'h18);
    pcm = pc;
    pc_do(PC_LOAD, 15'h7FFF);
    pc_do(PC_STEP, 15'h0000);
    wr(OFS_WORKING_REGISTER, 8'hA5);
    wr(OFS_BSR, 8'h07);
    pc_do(PC_LOAD, 15'h0123);
    pc_do(PC_IRQ, 15'h0000);
    wr(OFS_WORKING_REGISTER, 8'h3C);
    wr(OFS_BSR, 8'h09);
    pc_do(PC_RETFIE, 15'h0000);
    chk("shadow working_register", 8'hA5, working_register);
    rdv(OFS_BSR);
    chk("shadow bank", 8'h07, rd);
    pc_do(PC_IRQ, 15'h0000);
    @(posedge mclk);
    pc_do(PC_RETFIE, 15'h0000);
    chk("shadow idle", 8'hA5, working_register);
    for (int i = 0; i < 17; i++) pc_do(PC_CALL, 15'(100 + i));
    repeat (2) @(posedge mclk);
    chk("overflow", 1, ovf);
    chk("soft reset", 1, 16'(srcnt));
    flag_clr(2'b01);
    chk("overflow clr", 0, ovf);
    @(posedge mclk);
    sre <= 1'b0;
    for (int i = 0; i < 17; i++) pc_do(PC_RET, 15'h0000);
    repeat (2) @(posedge mclk);
    chk("underflow", 1, unf);
    chk("no soft reset", 1, 16'(srcnt));
    flag_clr(2'b10);
    chk("underflow clr", 0, unf);
    summarize();
  end
endmodule : core_memory_addressing_tb
`default_nettype wire
